// *** inc/dma_host_params.svh ***
`ifndef DMA_HOST_PARAMS_SVH
`define DMA_HOST_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define A_CTRL 8'h00
`define A_LEN 8'h04
`define A_CNT 8'h08
`define A_ADDR 8'h0c
`define A_STAT 8'h10
// ****************************************
// control and status fields
// ****************************************
`define C_START 0
`define C_WRITE 1
`define C_ROUND 2
`define C_GUARD 3
`define C_CHK_LO 4
`define C_CHK_HI 6
`define S_BUSY 0
`define S_DONE 1
`define S_CHAIN 2
`define CTRL_RST 7'h00
// ****************************************
// beat timing
// ****************************************
`define PH_LAST 3'h5
`define PH_STRB 3'h1
`define PH_DATA 3'h2
`define WORD_STEP 32'h4
`define BYTE_STEP 32'h1
`endif

// *** inc/dma_host_pkg.sv ***
package dma_host_pkg;
    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_RDY = 10'h002,
        S_ARM = 10'h004,
        S_WORD = 10'h008,
        S_BYTE = 10'h010,
        S_DRAIN = 10'h020,
        S_ARG = 10'h040,
        S_CMD = 10'h080,
        S_FIN = 10'h100,
        S_END = 10'h200
    } state_t;
    typedef struct packed {
        logic we;
        logic re;
        logic [3:0] be;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic byte_w;
        logic [31:0] wdata;
    } fifo_req_t;
    typedef struct packed {
        logic dma_en;
        logic round;
        logic guard;
        logic [1:0] offset;
        logic [2:0] chunk;
    } host_cfg_t;
    typedef struct packed {
        logic req;
        logic cmd_ready;
        logic not_busy;
        logic fifo_empty;
        logic xfer_done;
    } dev_stat_t;
endpackage : dma_host_pkg

// *** logic/dma_host.sv ***
// Functional notes
// - rounding off: exact bytes, word then byte
// - word count len/4, zero skips it
// - byte part moves len[1:0] bytes
// - word part links to byte part
// - start at words from four up
// - byte destination follows words, else free
// - rounding on: ceil(len/4) words once
// - read: fifo source, aligned destination, handshake
// - write: low source bits become offset
// - write words ceil((len+offset)/4) per block
// - write: fifo destination, contiguous source
// - wait command ready and not busy
// - one block per descriptor, null ends
// - chain done, fifo empty, argument, command
// - chunk size matches device chunk field
// - separate layers allow parallel prefetch
// - start clears stale channel events
// - linked sequence reloads control per step
// - reads set the read stall guard
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dma_host_params.svh"
module dma_host (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire dma_host_pkg::dev_stat_t i_dev,
    input wire logic [31:0] i_fifo_rdata,
    output dma_host_pkg::fifo_req_t o_fifo,
    output dma_host_pkg::host_cfg_t o_cfg,
    output logic o_arg_wr,
    output logic o_cmd_wr,
    input wire logic [31:0] i_mem_rdata,
    output dma_host_pkg::mem_req_t o_mem
);
    import dma_host_pkg::*;
    // ****************************************
    // pin synchroniser
    // ****************************************
    dev_stat_t ds1_q;
    dev_stat_t hs;
    always_ff @(posedge i_clk_sys)
    begin
        ds1_q <= i_dev;
        hs <= ds1_q;
    end
    // ****************************************
    // apb slave
    // ****************************************
    logic [6:0] ctrl_q;
    logic [15:0] len_q;
    logic [15:0] cnt_q;
    logic [31:0] base_q;
    logic done_q;
    logic chain_q;
    state_t st_q;
    state_t st_d;
    wire setup = i_psel && !i_penable;
    wire acc_wr = i_psel && i_penable && o_pready && i_pwrite;
    wire [7:0] a8 = i_paddr[7:0];
    wire hit_ctrl = a8 == `A_CTRL;
    wire hit_len = a8 == `A_LEN;
    wire hit_cnt = a8 == `A_CNT;
    wire hit_addr = a8 == `A_ADDR;
    wire hit_stat = a8 == `A_STAT;
    wire hit_any = i_paddr[31:8] == 24'h0 &&
        (hit_ctrl || hit_len || hit_cnt || hit_addr || hit_stat);
    wire busy = st_q != S_IDLE;
    wire [31:0] stat_w = {24'h0, hs.fifo_empty, hs.not_busy,
        hs.cmd_ready, hs.xfer_done, 1'b0, chain_q, done_q, busy};
    wire [31:0] rd_mux = !hit_any ? 32'h0 :
        hit_ctrl ? {25'h0, ctrl_q} :
        hit_len ? {16'h0, len_q} :
        hit_cnt ? {16'h0, cnt_q} :
        hit_addr ? base_q : stat_w;
    wire start = acc_wr && hit_any && hit_ctrl &&
        i_pwdata[`C_START] && !busy;
    wire clr_done = acc_wr && hit_any && hit_stat && i_pwdata[`S_DONE];
    wire clr_chain = acc_wr && hit_any && hit_stat && i_pwdata[`S_CHAIN];
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end
        else
        begin
            o_pready <= setup;
            o_pslverr <= setup && !hit_any;
            o_prdata <= setup ? rd_mux : 32'h0;
        end
    end
    // config only accepted while idle; a live transfer keeps its setup
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            ctrl_q <= `CTRL_RST;
            len_q <= 16'h0;
            cnt_q <= 16'h0;
            base_q <= 32'h0;
        end
        else if (acc_wr && hit_any && !busy)
        begin
            if (hit_ctrl)
                ctrl_q <= {i_pwdata[6:1], 1'b0};
            if (hit_len)
                len_q <= i_pwdata[15:0];
            if (hit_cnt)
                cnt_q <= i_pwdata[15:0];
            if (hit_addr)
                base_q <= i_pwdata;
        end
    end
    // ****************************************
    // transfer sizing
    // ****************************************
    wire is_wr = ctrl_q[`C_WRITE];
    wire is_rnd = ctrl_q[`C_ROUND];
    wire [1:0] off = is_wr ? base_q[1:0] : 2'h0;
    wire [15:0] full_words = {2'h0, len_q[15:2]};
    wire [15:0] tail_bytes = {14'h0, len_q[1:0]};
    wire [16:0] rsum = {1'b0, len_q} + 17'h3;
    wire [15:0] rnd_words = {1'b0, rsum[16:2]};
    wire [16:0] wsum = {1'b0, len_q} + {15'h0, off} + 17'h3;
    wire [15:0] wr_words = {1'b0, wsum[16:2]};
    // ****************************************
    // beat engine
    // ****************************************
    logic [2:0] ph_q;
    logic [15:0] beats_q;
    logic [15:0] blk_q;
    logic [15:0] nbeat_q;
    logic [31:0] addr_q;
    wire moving = st_q == S_WORD || st_q == S_BYTE;
    wire byte_ph = st_q == S_BYTE;
    wire go = moving && ph_q == 3'h0 && hs.req && beats_q != 16'h0;
    wire capt = ph_q == `PH_DATA;
    wire idle_ph = ph_q == 3'h0;
    wire part_end = moving && idle_ph && beats_q == 16'h0;
    wire [31:0] step = byte_ph ? `BYTE_STEP : `WORD_STEP;
    wire [31:0] src_word = is_wr ? i_mem_rdata : i_fifo_rdata;
    wire [3:0] lane = 4'h1 << addr_q[1:0];
    wire last_blk = blk_q <= 16'h1;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst || !moving)
            ph_q <= 3'h0;
        else if (go || (ph_q != 3'h0 && ph_q != `PH_LAST))
            ph_q <= ph_q + 3'h1;
        else
            ph_q <= 3'h0;
    end
    // ****************************************
    // sequencer
    // ****************************************
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            S_IDLE:
                if (start)
                    st_d = S_RDY;
            S_RDY:
                if (hs.cmd_ready && hs.not_busy)
                    st_d = S_ARM;
            S_ARM:
                st_d = (!is_wr && !is_rnd && len_q <= 16'h4 &&
                    full_words == 16'h0) ? S_BYTE : S_WORD;
            S_WORD:
                if (part_end)
                begin
                    // link to byte part, next write block, drain or end
                    if (!is_wr && !is_rnd && tail_bytes != 16'h0)
                        st_d = S_BYTE;
                    else if (is_wr && !last_blk)
                        st_d = S_WORD;
                    else if (is_wr)
                        st_d = S_DRAIN;
                    else
                        st_d = S_FIN;
                end
            S_BYTE:
                if (part_end)
                    st_d = S_FIN;
            S_DRAIN:
                if (hs.fifo_empty)
                    st_d = S_ARG;
            S_ARG:
                st_d = S_CMD;
            S_CMD:
                st_d = S_FIN;
            S_FIN:
                if (hs.xfer_done)
                    st_d = S_END;
            S_END:
                st_d = S_IDLE;
            default:
                st_d = S_IDLE;
        endcase
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            st_q <= S_IDLE;
        else
            st_q <= st_d;
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst || start)
        begin
            done_q <= 1'b0;
            chain_q <= 1'b0;
        end
        else
        begin
            done_q <= (st_q == S_END) || (done_q && !clr_done);
            chain_q <= (st_q == S_WORD && st_d == S_DRAIN) ||
                (chain_q && !clr_chain);
        end
    end
    // ****************************************
    // descriptor counters
    // ****************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            beats_q <= 16'h0;
            blk_q <= 16'h0;
            nbeat_q <= 16'h0;
        end
        else if (st_q == S_ARM)
        begin
            blk_q <= cnt_q;
            nbeat_q <= 16'h0;
            if (is_wr)
                beats_q <= wr_words;
            else if (is_rnd)
                beats_q <= rnd_words;
            else if (st_d == S_BYTE)
                beats_q <= tail_bytes;
            else
                beats_q <= full_words;
        end
        else if (part_end && st_d == S_BYTE)
            beats_q <= tail_bytes;
        else if (part_end && st_d == S_WORD)
        begin
            beats_q <= wr_words;
            blk_q <= blk_q - 16'h1;
        end
        else if (capt)
        begin
            beats_q <= beats_q - 16'h1;
            nbeat_q <= nbeat_q + 16'h1;
        end
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            addr_q <= 32'h0;
        else if (st_q == S_ARM)
            addr_q <= (is_wr || st_d == S_WORD) ?
                {base_q[31:2], 2'h0} : base_q;
        else if (capt)
            addr_q <= addr_q + step;
    end
    // ****************************************
    // port strobes
    // ****************************************
    // source and sink ports independent
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            o_fifo <= '0;
            o_mem <= '0;
        end
        else
        begin
            o_fifo.rd <= go && !is_wr;
            o_fifo.byte_w <= moving && byte_ph;
            o_fifo.wr <= capt && is_wr;
            o_fifo.wdata <= capt ? src_word : o_fifo.wdata;
            o_mem.re <= go && is_wr;
            o_mem.we <= capt && !is_wr;
            o_mem.be <= byte_ph ? lane : 4'hf;
            o_mem.addr <= addr_q;
            o_mem.wdata <= byte_ph ? {4{src_word[7:0]}} : src_word;
        end
    end
    // ****************************************
    // device configuration
    // ****************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            o_cfg <= '0;
            o_arg_wr <= 1'b0;
            o_cmd_wr <= 1'b0;
        end
        else
        begin
            o_cfg.dma_en <= st_d == S_WORD || st_d == S_BYTE ||
                (o_cfg.dma_en && st_d != S_IDLE && st_d != S_RDY);
            if (st_q == S_RDY)
            begin
                o_cfg.round <= is_rnd;
                o_cfg.guard <= !is_wr || ctrl_q[`C_GUARD];
                o_cfg.offset <= off;
                o_cfg.chunk <= ctrl_q[`C_CHK_HI:`C_CHK_LO];
            end
            o_arg_wr <= st_q == S_ARG;
            o_cmd_wr <= st_q == S_CMD;
        end
    end
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);
    a_en_off_setup: assert property (st_q == S_RDY |=> !o_cfg.dma_en)
        else $error("enable high during setup");
    a_rdy_gate_hold: assert property (
        st_q == S_RDY && !(hs.cmd_ready && hs.not_busy) |=> st_q == S_RDY)
        else $error("left ready wait early");
    a_arg_cmd_order: assert property (o_arg_wr |=> o_cmd_wr ##1 !o_cmd_wr)
        else $error("stop command order broken");
    a_stop_after_empty: assert property ($rose(o_arg_wr) |-> $past(hs.fifo_empty, 2))
        else $error("stop before fifo empty");
    a_word_dest_align: assert property (
        o_mem.we && !o_fifo.byte_w |-> o_mem.addr[1:0] == 2'h0)
        else $error("word write unaligned");
    a_round_count: assert property (
        st_q == S_WORD && st_d == S_FIN && is_rnd |-> nbeat_q == rnd_words)
        else $error("rounded word count wrong");
    a_skip_zero: assert property (
        st_q == S_ARM && !is_wr && !is_rnd && full_words == 16'h0 |=> st_q == S_BYTE)
        else $error("empty word part not skipped");
    a_null_next: assert property (
        st_q == S_WORD && part_end && !is_wr && !is_rnd && tail_bytes == 16'h0
        |=> st_q == S_FIN)
        else $error("null link not honoured");
    a_beat_gap: assert property (o_fifo.rd |=> !o_fifo.rd [*4])
        else $error("fifo beats too close");
endmodule : dma_host
`default_nettype wire

// *** tb/card_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// card host device model
// ****************************************
module card_host_model (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [15:0] i_len,
    input wire logic [15:0] i_blocks,
    input wire logic i_write,
    input wire logic i_hold_busy,
    input wire dma_host_pkg::host_cfg_t i_cfg,
    input wire dma_host_pkg::fifo_req_t i_fifo,
    input wire logic i_cmd_wr,
    output dma_host_pkg::dev_stat_t o_dev,
    output logic [31:0] o_rdata
);
    import dma_host_pkg::*;
    logic [31:0] left_q;
    logic [31:0] beat_q;
    logic en_q;
    logic cmd_q;
    logic done_q;
    logic [31:0] len32;
    logic [31:0] rd_total;
    logic [31:0] wr_total;
    logic [31:0] step;
    assign len32 = {16'h0, i_len};
    assign rd_total = i_cfg.round ? ((len32 + 32'h3) & ~32'h3) : len32;
    assign wr_total = ((len32 + {30'h0, i_cfg.offset} + 32'h3) & ~32'h3)
        * ((i_blocks == 16'h0) ? 32'h1 : {16'h0, i_blocks});
    assign step = i_fifo.byte_w ? 32'h1 : 32'h4;
    assign o_dev = {i_cfg.dma_en && en_q && (left_q != 32'h0), 1'b1, !i_hold_busy,
        left_q == 32'h0, done_q};
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            left_q <= 32'h0;
            beat_q <= 32'h10000000;
            en_q <= 1'b0;
            cmd_q <= 1'b0;
            done_q <= 1'b0;
            o_rdata <= 32'h0;
        end
        else
        begin
            en_q <= i_cfg.dma_en;
            // stale data inverted every cycle, so it matches again on alternate cycles
            o_rdata <= i_fifo.rd ? beat_q : ~o_rdata;
            if (i_cmd_wr)
                cmd_q <= 1'b1;
            if (i_cfg.dma_en && !en_q)
            begin
                left_q <= i_write ? wr_total : rd_total;
                beat_q <= 32'h10000000;
                cmd_q <= 1'b0;
                done_q <= 1'b0;
            end
            else
            begin
                if (i_fifo.rd || i_fifo.wr)
                    left_q <= (left_q > step) ? left_q - step : 32'h0;
                if (i_fifo.rd)
                    beat_q <= beat_q + 32'h1;
                if (en_q && left_q == 32'h0 && (!i_write || cmd_q))
                    done_q <= 1'b1;
            end
        end
    end
endmodule : card_host_model
`default_nettype wire

// *** tb/dma_host_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dma_host_params.svh"
module dma_host_bench;
    import dma_host_pkg::*;
    typedef struct {
        logic [15:0] len;
        logic rnd;
        logic [31:0] addr;
        logic [2:0] chk;
        logic [7:0] ew;
        logic [7:0] eb;
    } row_t;
    // ****************************************
    // signals
    // ****************************************
    logic clk, rst, psel, penable, pwrite, pready, pslverr, arg_wr, cmd_wr;
    logic m_wr, hold, cur_rnd, cur_grd, arg_seen, err;
    logic [2:0] cur_chk;
    logic [1:0] cur_off;
    logic [15:0] m_len, m_blk;
    logic [31:0] paddr, pwdata, prdata, mem_rdata, fifo_rdata, base, bbase, s;
    int fail_count, samples_checked, nw, nb, nr;
    logic [31:0] rq[$];
    dev_stat_t dev;
    fifo_req_t fifo;
    host_cfg_t cfg;
    mem_req_t mem;
    row_t rows[7] = '{
        '{16'h8, 1'b0, 32'h2000, 3'h1, 8'h2, 8'h0}, '{16'h6, 1'b0, 32'h2000, 3'h2, 8'h1, 8'h2},
        '{16'h3, 1'b0, 32'h2001, 3'h3, 8'h0, 8'h3}, '{16'h6, 1'b1, 32'h2000, 3'h4, 8'h2, 8'h0},
        '{16'h4, 1'b0, 32'h2000, 3'h0, 8'h1, 8'h0}, '{16'h5, 1'b0, 32'h2000, 3'h7, 8'h1, 8'h1},
        '{16'h7, 1'b1, 32'h3000, 3'h5, 8'h2, 8'h0}};
    dma_host uut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_dev(dev), .i_fifo_rdata(fifo_rdata),
        .o_fifo(fifo), .o_cfg(cfg), .o_arg_wr(arg_wr), .o_cmd_wr(cmd_wr),
        .i_mem_rdata(mem_rdata), .o_mem(mem));
    card_host_model dev_model (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_len(m_len), .i_blocks(m_blk), .i_write(m_wr),
        .i_hold_busy(hold), .i_cfg(cfg), .i_fifo(fifo), .i_cmd_wr(cmd_wr), .o_dev(dev),
        .o_rdata(fifo_rdata));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic bound(input int n, input int lim);
        if (n >= lim)
        begin
            fail_count++;
            end_sim();
        end
    endtask : bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        bound(n, 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r, err);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        apb(1'b0, a, 32'h0, d, err);
    endtask : rd
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            rd(`A_STAT, s);
            n++;
        end
        while (s[0] !== 1'b0 && n < 300);
        bound(n, 300);
    endtask : wait_idle
    task automatic start(input logic [15:0] len, input logic [15:0] blk,
        input logic [31:0] addr, input logic [31:0] ctrl);
        m_len <= len;
        m_blk <= blk;
        m_wr <= ctrl[1];
        cur_rnd = ctrl[2];
        cur_grd = ctrl[3];
        cur_chk = ctrl[6:4];
        cur_off = addr[1:0];
        base = {addr[31:2], 2'h0};
        nw = 0;
        nb = 0;
        nr = 0;
        arg_seen = 1'b0;
        wr(`A_LEN, {16'h0, len});
        wr(`A_ADDR, addr);
        wr(`A_CNT, {16'h0, blk});
        wr(`A_CTRL, ctrl);
    endtask : start
    // ****************************************
    // monitor and memory
    // ****************************************
    always @(posedge clk)
    begin
        mem_rdata <= mem.re ? ~mem.addr : ~mem_rdata;
        if (!rst && (fifo.rd || fifo.wr))
        begin
            chk("dma_en", 32'h1, {31'h0, cfg.dma_en});
            chk("chunk", {29'h0, cur_chk}, {29'h0, cfg.chunk});
        end
        if (!rst && fifo.rd)
        begin
            chk("guard", 32'h1, {31'h0, cfg.guard});
            chk("round", {31'h0, cur_rnd}, {31'h0, cfg.round});
        end
        if (!rst && fifo.wr)
        begin
            chk("offset", {30'h0, cur_off}, {30'h0, cfg.offset});
            chk("write guard", {31'h0, cur_grd}, {31'h0, cfg.guard});
            chk("fifo data", rq.size() > 0 ? rq.pop_front() : 32'h0, fifo.wdata);
        end
        if (!rst && mem.we && mem.be === 4'hf)
        begin
            chk("word addr", base + 32'(nw) * 4, mem.addr);
            chk("word data", 32'h10000000 + 32'(nw), mem.wdata);
            nw++;
        end
        else if (!rst && mem.we)
        begin
            chk("byte addr", bbase + 32'(nb), mem.addr);
            chk("byte lane", 32'(4'h1 << mem.addr[1:0]), {28'h0, mem.be});
            chk("byte data", 32'(8'(nw + nb)), 32'(mem.wdata[8 * mem.addr[1:0] +: 8]));
            nb++;
        end
        if (!rst && mem.re)
        begin
            chk("src addr", base + 32'(nr) * 4, mem.addr);
            rq.push_back(~mem.addr);
            nr++;
        end
        if (!rst && arg_wr)
        begin
            chk("empty at stop", 32'h1, {31'h0, dev.fifo_empty});
            arg_seen = 1'b1;
        end
        if (!rst && cmd_wr)
            chk("argument first", 32'h1, {31'h0, arg_seen});
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever
            #2.5 clk = ~clk;
    end
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        mem_rdata = 32'h0;
        m_len = 16'h0;
        m_blk = 16'h0;
        m_wr = 1'b0;
        hold = 1'b0;
        arg_seen = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            bbase = rows[i].addr + 32'(rows[i].ew) * 4;
            start(rows[i].len, 16'h1, rows[i].addr,
                {25'h0, rows[i].chk, 1'b0, rows[i].rnd, 2'h1});
            wait_idle();
            chk("word beats", {24'h0, rows[i].ew}, 32'(nw));
            chk("byte beats", {24'h0, rows[i].eb}, 32'(nb));
            rd(`A_STAT, s);
            chk("read done", 32'h2, s & 32'h3);
        end
        // card busy must hold the write back
        hold <= 1'b1;
        start(16'h6, 16'h2, 32'h1001, 32'h6b);
        wr(`A_LEN, 32'h55);
        rd(`A_STAT, s);
        chk("busy", 32'h1, s & 32'h1);
        chk("held beats", 32'h0, 32'(nr));
        hold <= 1'b0;
        wait_idle();
        chk("write words", 32'h4, 32'(nr));
        rd(`A_LEN, s);
        chk("len kept", 32'h6, s);
        rd(`A_STAT, s);
        chk("write status", 32'h6, s & 32'h7);
        chk("stop sent", 32'h1, {31'h0, arg_seen});
        wr(`A_STAT, 32'h6);
        rd(`A_STAT, s);
        chk("status clear", 32'h0, s & 32'h7);
        apb(1'b0, 8'h20, 32'h0, s, err);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, s);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("cfg reset", 32'h0, {24'h0, cfg});
        rd(`A_STAT, s);
        chk("status reset", 32'he0, s);
        end_sim();
    end
endmodule : dma_host_bench
`default_nettype wire
